// File: fan_count_latch.sv
/*
  per-fan latch: freezes the pulse count of one tachometer measurement
  at its start so that a later register write cannot disturb it.
  assumes: start and done are one-cycle pulses from the period counter.
*/
`timescale 1ns/1ps
module fan_count_latch
  import tach_cfg_pkg::*;
(
  input  wire logic                           core_clk_i,     // core clock
  input  wire logic                           rstn_i,         // sync reset, low
  input  wire logic [tach_cfg_pkg::SEL_W-1:0] sel_i,          // live select field
  input  wire logic                           meas_start_i,   // measurement begins
  input  wire logic                           meas_done_i,    // measurement ends
  output logic      [tach_cfg_pkg::CNT_W-1:0] pulse_count_o,  // frozen count
  output logic                                meas_busy_o     // measurement running
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    latch_state_e            st;   // idle or busy
    logic [CNT_W-1:0]        cnt;  // count in force
  } latch_s;

  latch_s cur_r;  // registered state
  latch_s cur_nxt;  // next state

  ////////////////////////////////////////////////////////////////////////////
  // next state: latch on start while idle, release on done
  always_comb begin
    cur_nxt = cur_r;
    case (cur_r.st)
      LATCH_IDLE: begin
        if (meas_start_i) begin
          cur_nxt.cnt = sel_to_count(sel_i);
          cur_nxt.st  = LATCH_BUSY;
        end
      end
      LATCH_BUSY: begin
        // starts during a run are ignored, count stays frozen
        if (meas_done_i) begin
          cur_nxt.st = LATCH_IDLE;
        end
      end
      default: begin
        cur_nxt.st = LATCH_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cur_r.st  <= LATCH_IDLE;
      cur_r.cnt <= CNT_RESET;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign pulse_count_o = cur_r.cnt;
  assign meas_busy_o   = (cur_r.st == LATCH_BUSY);

endmodule

// File: fan_tach_model.sv
/*
  behavioural stand-in for the tachometer period counters: turns a
  request into a start pulse and, after a chosen number of cycles,
  a done pulse for each fan.
  assumes: requests and hold length change only on the falling edge.
*/
`timescale 1ns/1ps
module fan_tach_model (
  input  wire logic       core_clk_i,     // core clock
  input  wire logic [3:0] trig_i,         // per fan request, one cycle
  input  wire logic [7:0] hold_i,         // cycles from start to done, 0 never
  output logic      [3:0] meas_start_o,   // start pulses
  output logic      [3:0] meas_done_o     // done pulses
);
  logic [7:0] cnt_r [4];                  // cycles left per fan

  initial begin
    meas_start_o = 4'h0;
    meas_done_o  = 4'h0;
    foreach (cnt_r[f]) cnt_r[f] = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulses launched on the falling edge, away from the sampling edge
  always @(negedge core_clk_i) begin
    logic [3:0] done_v;                   // done pulses for this edge
    done_v = 4'h0;
    for (int f = 0; f < 4; f++) begin
      if (trig_i[f]) begin
        cnt_r[f] <= hold_i;               // arm the done countdown
      end else if (cnt_r[f] == 8'h01) begin
        done_v[f] = 1'b1;                 // measurement ends
        cnt_r[f]  <= 8'h00;
      end else if (cnt_r[f] > 8'h01) begin
        cnt_r[f] <= cnt_r[f] - 8'h01;
      end
    end
    meas_start_o <= trig_i;
    meas_done_o  <= done_v;
  end
endmodule

// File: tach_cfg_pkg.sv
/*
  constants, types and helpers shared by the tachometer pulse-count
  configuration register and its per-fan measurement latch.
  assumes: one 100 MHz core clock, synchronous active-low reset.
*/
package tach_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned ADDR_W  = 8;  // register address width
  localparam int unsigned DATA_W  = 8;  // register data width
  localparam int unsigned FAN_NUM = 4;  // tachometer inputs
  localparam int unsigned SEL_W   = 2;  // per-fan select field width
  localparam int unsigned CNT_W   = 3;  // pulse count, 1 to 4

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [ADDR_W-1:0] TPC_SEL_OFFSET = 8'h7B;  // pulse count select
  localparam logic [DATA_W-1:0] TPC_SEL_RESET  = 8'h55;  // every field code 01
  localparam logic [DATA_W-1:0] RD_UNMAPPED    = 8'h00;  // unmapped read value

  // field positions, low bit of each two-bit field
  localparam int unsigned FIRST_FAN_LSB  = 0;
  localparam int unsigned SECOND_FAN_LSB = 2;
  localparam int unsigned THIRD_FAN_LSB  = 4;
  localparam int unsigned FOURTH_FAN_LSB = 6;

  // latched count before the first measurement, matches code 01
  localparam logic [CNT_W-1:0] CNT_RESET = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // measurement latch states
  typedef enum logic [0:0] {
    LATCH_IDLE = 1'b0,  // waiting for a measurement start
    LATCH_BUSY = 1'b1   // measurement running, count frozen
  } latch_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // code n selects n plus one counted pulses
  function automatic logic [CNT_W-1:0] sel_to_count(input logic [SEL_W-1:0] code);
    sel_to_count = {1'b0, code} + 3'h1;
  endfunction

endpackage

// File: tach_pulse_count_config.sv
/*
  pulse-count select register for four fan speed measurements, with a
  latch per fan that holds the count for the whole of one measurement.
  assumes: register port is driven by the management serial interface
  decoder in the core clock domain; start/done pulses come from the
  tachometer period counters.
*/
// Summary of operation
// - bits 1:0 pick fan 1 pulse count
// - bits 3:2 pick fan 2 pulse count
// - bits 5:4 pick fan 3 pulse count
// - bits 7:6 pick fan 4 pulse count
// - reset loads 0x55, two pulses each
`timescale 1ns/1ps
module tach_pulse_count_config
  import tach_cfg_pkg::*;
(
  input  wire logic                                           core_clk_i,
  input  wire logic                                           rstn_i,
  input  wire logic                                           wr_en_i,
  input  wire logic                                           rd_en_i,
  input  wire logic [tach_cfg_pkg::ADDR_W-1:0]                addr_i,
  input  wire logic [tach_cfg_pkg::DATA_W-1:0]                wdata_i,
  output logic      [tach_cfg_pkg::DATA_W-1:0]                rdata_o,
  input  wire logic [tach_cfg_pkg::FAN_NUM-1:0]               meas_start_i,
  input  wire logic [tach_cfg_pkg::FAN_NUM-1:0]               meas_done_i,
  output logic      [tach_cfg_pkg::SEL_W-1:0]                 first_fan_pulse_count_sel_o,
  output logic      [tach_cfg_pkg::SEL_W-1:0]                 second_fan_pulse_count_sel_o,
  output logic      [tach_cfg_pkg::SEL_W-1:0]                 third_fan_pulse_count_sel_o,
  output logic      [tach_cfg_pkg::SEL_W-1:0]                 fourth_fan_pulse_count_sel_o,
  output logic      [tach_cfg_pkg::FAN_NUM*tach_cfg_pkg::CNT_W-1:0] pulse_count_o,
  output logic      [tach_cfg_pkg::FAN_NUM-1:0]               meas_busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [DATA_W-1:0] sel;    // pulse count select register
    logic [DATA_W-1:0] rdata;  // read data held for the bus
  } cfg_s;

  cfg_s cur_r;    // registered state
  cfg_s cur_nxt;  // next state

  logic                  hit;                  // address decodes to the register
  logic [SEL_W-1:0]      fan_sel [FAN_NUM];    // per-fan field of the register

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign hit = (addr_i == TPC_SEL_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // register write and read
  always_comb begin
    cur_nxt = cur_r;
    // write: whole byte, all four fields, unmapped writes dropped
    if (wr_en_i && hit) begin
      cur_nxt.sel = wdata_i;
    end
    // read: register or zero for an unmapped address
    if (rd_en_i) begin
      if (hit) begin
        cur_nxt.rdata = cur_r.sel;
      end else begin
        cur_nxt.rdata = RD_UNMAPPED;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, power-on value gives two pulses on every fan
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cur_r.sel   <= TPC_SEL_RESET;
      cur_r.rdata <= RD_UNMAPPED;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field split
  assign fan_sel[0] = cur_r.sel[FIRST_FAN_LSB +: SEL_W];
  assign fan_sel[1] = cur_r.sel[SECOND_FAN_LSB +: SEL_W];
  assign fan_sel[2] = cur_r.sel[THIRD_FAN_LSB +: SEL_W];
  assign fan_sel[3] = cur_r.sel[FOURTH_FAN_LSB +: SEL_W];

  assign rdata_o                      = cur_r.rdata;
  assign first_fan_pulse_count_sel_o  = fan_sel[0];
  assign second_fan_pulse_count_sel_o = fan_sel[1];
  assign third_fan_pulse_count_sel_o  = fan_sel[2];
  assign fourth_fan_pulse_count_sel_o = fan_sel[3];

  ////////////////////////////////////////////////////////////////////////////
  // one latch per fan, count frozen at measurement start
  for (genvar g = 0; g < FAN_NUM; g++) begin : g_fan
    fan_count_latch i_fan_count_latch (
      .core_clk_i    (core_clk_i),
      .rstn_i        (rstn_i),
      .sel_i         (fan_sel[g]),
      .meas_start_i  (meas_start_i[g]),
      .meas_done_i   (meas_done_i[g]),
      .pulse_count_o (pulse_count_o[g*CNT_W +: CNT_W]),
      .meas_busy_o   (meas_busy_o[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // a start accepted on an idle fan
  sequence s_start(int unsigned f);
    !meas_busy_o[f] && meas_start_i[f];
  endsequence

  // a register write landing while a fan is measuring
  sequence s_write_busy(int unsigned f);
    meas_busy_o[f] && !meas_done_i[f] && wr_en_i && hit;
  endsequence

  // fan 1: start latches code + 1 from bits 1:0
  property p_first_fan_pulse_count_sel_count;
    @(posedge core_clk_i) disable iff (!rstn_i)
      s_start(0) |=> meas_busy_o[0] &&
        (pulse_count_o[2:0] == {1'b0, $past(cur_r.sel[1:0])} + 3'h1);
  endproperty
  a_first_fan_pulse_count_sel_count: assert property (p_first_fan_pulse_count_sel_count)
    else $error("fan 1 pulse count does not follow bits 1:0");

  // fan 2: start latches code + 1 from bits 3:2
  property p_second_fan_pulse_count_sel_count;
    @(posedge core_clk_i) disable iff (!rstn_i)
      s_start(1) |=> (pulse_count_o[5:3] == {1'b0, $past(cur_r.sel[3:2])} + 3'h1);
  endproperty
  a_second_fan_pulse_count_sel_count: assert property (p_second_fan_pulse_count_sel_count)
    else $error("fan 2 pulse count does not follow bits 3:2");

  // fan 3: start latches code + 1 from bits 5:4
  property p_third_fan_pulse_count_sel_count;
    @(posedge core_clk_i) disable iff (!rstn_i)
      s_start(2) |=> (pulse_count_o[8:6] == {1'b0, $past(cur_r.sel[5:4])} + 3'h1);
  endproperty
  a_third_fan_pulse_count_sel_count: assert property (p_third_fan_pulse_count_sel_count)
    else $error("fan 3 pulse count does not follow bits 5:4");

  // fan 4: start latches code + 1 from bits 7:6
  property p_fourth_fan_pulse_count_sel_count;
    @(posedge core_clk_i) disable iff (!rstn_i)
      s_start(3) |=> (pulse_count_o[11:9] == {1'b0, $past(cur_r.sel[7:6])} + 3'h1);
  endproperty
  a_fourth_fan_pulse_count_sel_count: assert property (p_fourth_fan_pulse_count_sel_count)
    else $error("fan 4 pulse count does not follow bits 7:6");

  // after reset release register reads 0x55 and each count is two
  property p_reset_value;
    @(posedge core_clk_i) disable iff (!rstn_i)
      $past(rstn_i) == 1'b0 |-> cur_r.sel == TPC_SEL_RESET &&
        pulse_count_o == {FAN_NUM{CNT_RESET}} && meas_busy_o == '0;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("power-on select or count is not the default");

  // a write during a fan 1 measurement leaves the fan 1 count alone
  property p_hold_first_fan_pulse_count_sel;
    @(posedge core_clk_i) disable iff (!rstn_i)
      s_write_busy(0) |=> $stable(pulse_count_o[2:0]) && meas_busy_o[0];
  endproperty
  a_hold_first_fan_pulse_count_sel: assert property (p_hold_first_fan_pulse_count_sel)
    else $error("fan 1 count changed during a measurement");

  // the written value is visible in the fan 1 and fan 4 fields one cycle later
  property p_write_lands;
    @(posedge core_clk_i) disable iff (!rstn_i)
      wr_en_i && hit |=> first_fan_pulse_count_sel_o == $past(wdata_i[1:0]) &&
        fourth_fan_pulse_count_sel_o == $past(wdata_i[7:6]);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("write to select register not taken");

  // busy measurement ignores further starts until done
  property p_busy_hold;
    @(posedge core_clk_i) disable iff (!rstn_i)
      meas_busy_o[2] && !meas_done_i[2] |=> meas_busy_o[2] && $stable(pulse_count_o[8:6]);
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("fan 3 count left its run early");

  // a mapped read returns the register as it stood at the read edge
  property p_read_back;
    @(posedge core_clk_i) disable iff (!rstn_i)
      rd_en_i && hit |=> rdata_o == $past(cur_r.sel);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read data does not match the select register");

  // a write also lands in the two middle fields
  property p_write_mid;
    @(posedge core_clk_i) disable iff (!rstn_i)
      wr_en_i && hit |=> second_fan_pulse_count_sel_o == $past(wdata_i[3:2]) &&
        third_fan_pulse_count_sel_o == $past(wdata_i[5:4]);
  endproperty
  a_write_mid: assert property (p_write_mid)
    else $error("write did not reach the middle select fields");

  // a start while fan 2 is measuring is refused
  property p_start_refused;
    @(posedge core_clk_i) disable iff (!rstn_i)
      meas_busy_o[1] && meas_start_i[1] && !meas_done_i[1] |=>
        meas_busy_o[1] && $stable(pulse_count_o[5:3]);
  endproperty
  a_start_refused: assert property (p_start_refused)
    else $error("fan 2 start taken during a measurement");

  // done ends the fan 4 run one cycle later
  property p_busy_release;
    @(posedge core_clk_i) disable iff (!rstn_i)
      meas_busy_o[3] && meas_done_i[3] |=> !meas_busy_o[3];
  endproperty
  a_busy_release: assert property (p_busy_release)
    else $error("fan 4 stayed busy after its done pulse");

endmodule

// File: tb_tach_pulse_count_config.sv
/*
  self-checking bench for the pulse-count select register and its
  per-fan measurement latches.
  assumes: inputs driven on the falling edge, 100 MHz core clock.
*/
`timescale 1ns/1ps
module tb_tach_pulse_count_config;
  import tach_cfg_pkg::*;
  logic        core_clk = 1'b0;           // core clock
  logic        rstn     = 1'b0;           // sync reset, low
  logic        wr_en    = 1'b0;           // write strobe
  logic        rd_en    = 1'b0;           // read strobe
  logic [7:0]  addr     = 8'h00;          // register address
  logic [7:0]  wdata    = 8'h00;          // write data
  logic [3:0]  trig     = 4'h0;           // model request
  logic [7:0]  hold     = 8'h04;          // model done delay
  logic [7:0]  rdata;                     // read data
  wire  [7:0]  sels;                      // four select fields joined
  logic [11:0] cnts;                      // frozen counts
  logic [3:0]  busy;                      // measurement running
  logic [3:0]  starts;                    // start pulses
  logic [3:0]  dones;                     // done pulses
  int          err_total       = 0;       // mismatches
  int          samples_checked = 0;       // comparisons

  always #5 core_clk = ~core_clk;

  fan_tach_model i_fan_tach_model (.core_clk_i(core_clk), .trig_i(trig), .hold_i(hold),
    .meas_start_o(starts), .meas_done_o(dones));

  tach_pulse_count_config i_tach_pulse_count_config (.core_clk_i(core_clk), .rstn_i(rstn),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .meas_start_i(starts), .meas_done_i(dones),
    .first_fan_pulse_count_sel_o(sels[1:0]), .second_fan_pulse_count_sel_o(sels[3:2]),
    .third_fan_pulse_count_sel_o(sels[5:4]), .fourth_fan_pulse_count_sel_o(sels[7:6]),
    .pulse_count_o(cnts), .meas_busy_o(busy));

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  // code n of each field gives n plus one pulses
  function automatic logic [11:0] exp_cnt(input logic [7:0] v);
    for (int f = 0; f < 4; f++) exp_cnt[3*f+:3] = {1'b0, v[2*f+:2]} + 3'h1;
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk) begin wr_en = 1'b1; addr = a; wdata = d; end
    @(negedge core_clk) wr_en = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk) begin rd_en = 1'b1; addr = a; end
    @(negedge core_clk) rd_en = 1'b0;
    d = rdata;
  endtask

  // bounded wait for the busy flags to reach a level
  task automatic wait_busy(input logic [3:0] lvl);
    int n;
    n = 0;
    while (busy !== lvl) begin
      @(negedge core_clk);
      n++;
      if (n > 60) begin
        $display("unexpected busy wait: expected %h seen %h", lvl, busy);
        err_total++;
        end_of_test();
      end
    end
  endtask

  task automatic measure(input logic [7:0] h);
    @(negedge core_clk) begin hold <= h; trig <= 4'hF; end
    @(negedge core_clk) trig <= 4'h0;
    wait_busy(4'hF);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic sc_reset();
    logic [7:0] d;
    chk("sel after reset", 12'h055, sels);
    chk("count after reset", 12'h492, cnts);
    reg_rd(TPC_SEL_OFFSET, d);
    chk("read after reset", 12'h055, d);
  endtask

  // codes 0 to 2 in every field and then 0xE4, each followed by the measurement that uses it
  task automatic sc_codes();
    logic [7:0] v;
    logic [7:0] d;
    for (int c = 0; c < 4; c++) begin
      v = {c[1:0], c[1:0], c[1:0], c[1:0]};
      if (c == 3) v = 8'hE4;
      reg_wr(TPC_SEL_OFFSET, v);
      chk("sel fields", v, sels);
      reg_rd(TPC_SEL_OFFSET, d);
      chk("read back", v, d);
      measure(8'h03);
      chk("counts", exp_cnt(v), cnts);
      wait_busy(4'h0);
    end
  endtask

  task automatic sc_unmapped();
    logic [7:0] d;
    reg_wr(8'h7C, 8'h1B);
    chk("sel after foreign write", 12'h0E4, sels);
    reg_rd(8'h7C, d);
    chk("unmapped read", RD_UNMAPPED, d);
  endtask

  // a write during a measurement waits for the next start
  task automatic sc_mid_write();
    reg_wr(TPC_SEL_OFFSET, 8'h00);
    measure(8'h28);
    reg_wr(TPC_SEL_OFFSET, 8'hFF);
    chk("sel mid measurement", 12'h0FF, sels);
    chk("count mid measurement", 12'h249, cnts);
    // a fresh start while busy is refused, count and busy hold
    @(negedge core_clk) trig <= 4'hF;
    @(negedge core_clk) trig <= 4'h0;
    @(negedge core_clk);
    chk("count after busy start", 12'h249, cnts);
    chk("busy after busy start", 12'h00F, busy);
    wait_busy(4'h0);
    measure(8'h02);
    chk("count next measurement", 12'h924, cnts);
    wait_busy(4'h0);
  endtask

  initial begin
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    sc_reset();
    sc_codes();
    sc_unmapped();
    sc_mid_write();
    end_of_test();
  end
endmodule
